// ### rtl/isr_cfg.svh
`ifndef ISR_CFG_SVH
`define ISR_CFG_SVH

// Register byte addresses
`define ISR_ADDR_STX 32'h4002_0834
`define ISR_ADDR_ALT 32'h4002_0838
`define ISR_ADDR_ID0 32'h4002_083C
`define ISR_ADDR_ID1 32'h4002_0840
`define ISR_ADDR_ID2 32'h4002_0844
`define ISR_ADDR_ID3 32'h4002_0848
`define ISR_ADDR_STAT 32'h4002_084C
`define ISR_ADDR_SHARED_DETECTOR_RESET 32'h4002_0850
`define ISR_ADDR_BUS_TIMING_CONTROL 32'h4002_0854
`define ISR_ADDR_ASTR 32'h4002_0858

// Reset values
`define ISR_RST_ZERO 16'h0000
`define ISR_RST_BUS_TIMING_CONTROL 16'h0205

// Field positions
`define ISR_STX_SEL_HI 9
`define ISR_STX_SEL_LO 8
`define ISR_STAT_FLUSH_ALL 10
`define ISR_STAT_MASTER_TX_FIFO_FLUSH 9
`define ISR_STAT_SLAVE_TX_FIFO_FLUSH 8
`define ISR_SHARED_DETECTOR_RESET_RESET 0
`define ISR_BUS_TIMING_CONTROL_FILT_HI 15
`define ISR_BUS_TIMING_CONTROL_FILT_LO 12
`define ISR_BUS_TIMING_CONTROL_PRE_HI 11
`define ISR_BUS_TIMING_CONTROL_PRE_LO 9
`define ISR_BUS_TIMING_CONTROL_FILT_EN 8
`define ISR_BUS_TIMING_CONTROL_HOLD_HI 5
`define ISR_BUS_TIMING_CONTROL_HOLD_LO 0
`define ISR_ASTR_ACK_CLR 15
`define ISR_ASTR_SSCL_IEN 14

// Transmit buffer shape
`define ISR_FIFO_DEPTH 32
`define ISR_FIFO_AW 5

`endif

// ### rtl/isr_pkg.sv
package isr_pkg;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } isr_apb_req_s;

    typedef struct packed {
        logic [1:0] id;
        logic [7:0] data;
    } isr_tx_s;

    typedef struct packed {
        logic [1:0] master_rx;
        logic [1:0] master_tx;
        logic [1:0] slave_rx;
        logic [1:0] slave_tx;
    } isr_fifo_cnt_s;

    typedef struct packed {
        logic [3:0] filter_ticks;
        logic [2:0] prescale_div;
        logic glitch_filter_control;
        logic [5:0] start_hold_qualify_count;
    } isr_timing_s;

endpackage : isr_pkg

// ### rtl/isr_regs.sv
// Operation
// - ID select in transmit writes picks per-ID FIFO, only in ID FIFO mode.
// - Select codes 00..11 pick FIFOs of matched slave IDs zero..three.
// - With hardware general call on, compare incoming byte to alt value.
// - Four address registers hold 7-bit IDs in bits 7:1; bit 0 ignored.
// - Flush-all in ID FIFO mode empties all four per-ID transmit FIFOs.
// - Master flush bit empties master transmit FIFO until software clears it.
// - Slave flush bit empties the single slave transmit FIFO until cleared.
// - Four read-only 2-bit byte counts report master and slave FIFO levels.
// - Shared reset bit resets start/stop detectors and clears line busy.
// - Four-bit filter tick field sets glitch width in clocks, reset zero.
// - Filter control bit set enables the glitch filter, cleared disables.
// - Three-bit prescale divide field for bus clock, resets to one.
// - Six-bit start/stop hold qualify count, resets to five.
// - Writing one to stretch bit 15 clears address acknowledge interrupt.
// - Stretch enable raises slave interrupt while hardware holds clock low.
// - After hardware general call, second byte is compared to alt value.
`timescale 1ns/1ps
`include "isr_cfg.svh"

module isr_tx_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = `ISR_FIFO_DEPTH,
    parameter int AW = `ISR_FIFO_AW
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic flush_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } isr_fifo_st_s;

    isr_fifo_st_s st_r;
    isr_fifo_st_s st_nxt;
    logic full;
    logic empty;

    assign empty = (st_r.wr == st_r.rd);
    assign full = (st_r.wr[AW-1:0] == st_r.rd[AW-1:0]) &&
                  (st_r.wr[AW] != st_r.rd[AW]);
    // Writes during a flush are accepted and dropped so the bus never hangs
    assign in_ready_o = !full || flush_i;
    assign out_valid_o = !empty && !flush_i;
    assign out_data_o = st_r.mem[st_r.rd[AW-1:0]];

    always_comb begin
        st_nxt = st_r;
        if (flush_i) begin
            st_nxt.wr = '0;
            st_nxt.rd = '0;
        end else begin
            if (in_valid_i && !full) begin
                st_nxt.mem[st_r.wr[AW-1:0]] = in_data_i;
                st_nxt.wr = st_r.wr + 1'b1;
            end
            if (out_ready_i && !empty) begin
                st_nxt.rd = st_r.rd + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_r.mem <= '0;
            st_r.wr <= '0;
            st_r.rd <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : isr_tx_fifo

module isr_regs
    import isr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Peripheral register bus (APB)
    input isr_apb_req_s apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // From slave control and protocol engines
    input wire logic per_id_fifo_mode_enable_i,
    input wire logic hw_general_call_enable_i,
    input isr_fifo_cnt_s fifo_cnt_i,
    input wire logic slave_scl_held_i,
    input wire logic addr_valid_i,
    input wire logic [7:0] addr_byte_i,
    input wire logic gc_byte_valid_i,
    input wire logic [7:0] gc_byte_i,
    // Slave transmit data stream
    output logic slave_tx_valid_o,
    input wire logic slave_tx_ready_i,
    output isr_tx_s slave_tx_o,
    // Controls to the engines
    output logic master_tx_fifo_flush_o,
    output logic slave_tx_fifo_flush_o,
    output logic flush_all_id_tx_fifos_o,
    output logic detector_reset_o,
    output isr_timing_s timing_o,
    output logic address_ack_irq_clear_o,
    output logic slave_stretch_irq_flag_o,
    output logic slave_irq_o,
    output logic addr_match_o,
    output logic [1:0] addr_match_id_o,
    output logic gc_alt_match_o
);
    typedef struct packed {
        logic [7:0] general_call_alt_value;
        logic [3:0][7:0] id;
        logic flush_all;
        logic fall;
        logic master_tx_fifo_flush;
        logic slave_tx_fifo_flush;
        logic det_rst;
        isr_timing_s timing;
        logic sscl_ien;
        logic ack_clr;
        logic sscl_flag;
        logic slv_irq;
        logic match;
        logic [1:0] match_id;
        logic alt_match;
        logic [1:0] stx_sel;
        logic [7:0] stx_data;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } isr_st_s;

    isr_st_s st_r;
    isr_st_s st_nxt;
    logic acc;
    logic hit_stx;
    logic stx_push;
    logic fifo_in_ready;
    logic fifo_flush;
    logic [15:0] rdata;
    logic hit;
    isr_tx_s push_word;
    // Register image of the reset value; bits 7:6 are reserved, not stored
    localparam logic [15:0] BUS_TIMING_CONTROL_RST = `ISR_RST_BUS_TIMING_CONTROL;

    assign acc = apb_i.sel && apb_i.enable && !st_r.pready;
    assign hit_stx = (apb_i.addr == `ISR_ADDR_STX);
    assign stx_push = acc && apb_i.write && hit_stx;
    // Without ID FIFO mode every byte goes to the single FIFO (code 00)
    assign push_word.id = per_id_fifo_mode_enable_i ?
        apb_i.wdata[`ISR_STX_SEL_HI:`ISR_STX_SEL_LO] : 2'h0;
    assign push_word.data = apb_i.wdata[7:0];
    assign fifo_flush = per_id_fifo_mode_enable_i ? st_r.flush_all
                                                  : st_r.slave_tx_fifo_flush;

    isr_tx_fifo #(
        .WIDTH(10),
        .DEPTH(`ISR_FIFO_DEPTH),
        .AW(`ISR_FIFO_AW)
    ) u_tx_fifo (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .flush_i(fifo_flush),
        .in_valid_i(stx_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(push_word),
        .out_valid_o(slave_tx_valid_o),
        .out_ready_i(slave_tx_ready_i),
        .out_data_o(slave_tx_o)
    );

    // Read mux, 16-bit registers, reserved and write-only bits zero
    always_comb begin
        rdata = 16'h0000;
        hit = 1'b1;
        unique case (apb_i.addr)
            `ISR_ADDR_STX: rdata = {6'h00, st_r.stx_sel, st_r.stx_data};
            `ISR_ADDR_ALT: rdata = {8'h00, st_r.general_call_alt_value};
            `ISR_ADDR_ID0: rdata = {8'h00, st_r.id[0]};
            `ISR_ADDR_ID1: rdata = {8'h00, st_r.id[1]};
            `ISR_ADDR_ID2: rdata = {8'h00, st_r.id[2]};
            `ISR_ADDR_ID3: rdata = {8'h00, st_r.id[3]};
            `ISR_ADDR_STAT: rdata = {5'h00, st_r.flush_all, 2'h0,
                                     fifo_cnt_i};
            `ISR_ADDR_SHARED_DETECTOR_RESET: rdata = 16'h0000;
            `ISR_ADDR_BUS_TIMING_CONTROL: rdata = {st_r.timing.filter_ticks,
                                     st_r.timing.prescale_div,
                                     st_r.timing.glitch_filter_control,
                                     2'h0,
                                     st_r.timing.start_hold_qualify_count};
            `ISR_ADDR_ASTR: rdata = {1'b0, st_r.sscl_ien, 14'h0000};
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        st_nxt.ack_clr = 1'b0;
        // Each access phase gets one wait state; SLAVE_TRANSMIT_DATA also waits on FIFO room
        if (acc && (!stx_push || fifo_in_ready)) begin
            st_nxt.pready = 1'b1;
            st_nxt.pslverr = !hit;
            st_nxt.prdata = apb_i.write ? 32'h0000_0000 : {16'h0000, rdata};
            if (apb_i.write) begin
                unique case (apb_i.addr)
                    `ISR_ADDR_STX: begin
                        st_nxt.stx_sel = push_word.id;
                        st_nxt.stx_data = push_word.data;
                    end
                    `ISR_ADDR_ALT: st_nxt.general_call_alt_value = apb_i.wdata[7:0];
                    `ISR_ADDR_ID0: st_nxt.id[0] = apb_i.wdata[7:0];
                    `ISR_ADDR_ID1: st_nxt.id[1] = apb_i.wdata[7:0];
                    `ISR_ADDR_ID2: st_nxt.id[2] = apb_i.wdata[7:0];
                    `ISR_ADDR_ID3: st_nxt.id[3] = apb_i.wdata[7:0];
                    `ISR_ADDR_STAT: begin
                        st_nxt.flush_all =
                            apb_i.wdata[`ISR_STAT_FLUSH_ALL];
                        st_nxt.master_tx_fifo_flush =
                            apb_i.wdata[`ISR_STAT_MASTER_TX_FIFO_FLUSH];
                        st_nxt.slave_tx_fifo_flush =
                            apb_i.wdata[`ISR_STAT_SLAVE_TX_FIFO_FLUSH];
                    end
                    `ISR_ADDR_SHARED_DETECTOR_RESET: st_nxt.det_rst =
                        apb_i.wdata[`ISR_SHARED_DETECTOR_RESET_RESET];
                    `ISR_ADDR_BUS_TIMING_CONTROL: begin
                        st_nxt.timing.filter_ticks = apb_i.wdata[
                            `ISR_BUS_TIMING_CONTROL_FILT_HI:`ISR_BUS_TIMING_CONTROL_FILT_LO];
                        st_nxt.timing.prescale_div = apb_i.wdata[
                            `ISR_BUS_TIMING_CONTROL_PRE_HI:`ISR_BUS_TIMING_CONTROL_PRE_LO];
                        st_nxt.timing.glitch_filter_control =
                            apb_i.wdata[`ISR_BUS_TIMING_CONTROL_FILT_EN];
                        st_nxt.timing.start_hold_qualify_count =
                            apb_i.wdata[`ISR_BUS_TIMING_CONTROL_HOLD_HI:
                                        `ISR_BUS_TIMING_CONTROL_HOLD_LO];
                    end
                    `ISR_ADDR_ASTR: begin
                        st_nxt.ack_clr =
                            apb_i.wdata[`ISR_ASTR_ACK_CLR];
                        st_nxt.sscl_ien = apb_i.wdata[`ISR_ASTR_SSCL_IEN];
                    end
                    default: ;
                endcase
            end
        end
        // Stretch status follows the hold; interrupt only when enabled
        st_nxt.sscl_flag = slave_scl_held_i;
        st_nxt.slv_irq = slave_scl_held_i && st_r.sscl_ien;
        // Lowest ID wins when two registers hold the same address
        st_nxt.match = 1'b0;
        st_nxt.match_id = 2'h0;
        if (addr_valid_i) begin
            for (int i = 3; i >= 0; i--) begin
                if (st_r.id[i][7:1] == addr_byte_i[7:1]) begin
                    st_nxt.match = 1'b1;
                    st_nxt.match_id = 2'(i);
                end
            end
        end
        st_nxt.alt_match = gc_byte_valid_i && hw_general_call_enable_i &&
                           (gc_byte_i == st_r.general_call_alt_value);
        // One cycle behind the bit, when the buffer has already been emptied
        st_nxt.fall = st_r.flush_all &&
                      per_id_fifo_mode_enable_i;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
            st_r.timing <= {BUS_TIMING_CONTROL_RST[15:8], BUS_TIMING_CONTROL_RST[5:0]};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata_o = st_r.prdata;
    assign pready_o = st_r.pready;
    assign pslverr_o = st_r.pslverr;
    assign master_tx_fifo_flush_o = st_r.master_tx_fifo_flush;
    assign slave_tx_fifo_flush_o = st_r.slave_tx_fifo_flush;
    assign flush_all_id_tx_fifos_o = st_r.fall;
    assign detector_reset_o = st_r.det_rst;
    assign timing_o = st_r.timing;
    assign address_ack_irq_clear_o = st_r.ack_clr;
    assign slave_stretch_irq_flag_o = st_r.sscl_flag;
    assign slave_irq_o = st_r.slv_irq;
    assign addr_match_o = st_r.match;
    assign addr_match_id_o = st_r.match_id;
    assign gc_alt_match_o = st_r.alt_match;
endmodule : isr_regs

// ### verif/i2c_slave_id_fifo_timing_regs_test.sv
`timescale 1ns/1ps
`include "isr_cfg.svh"
module i2c_slave_id_fifo_timing_regs_test;
    import isr_pkg::*;
    localparam logic [31:0] RA[9] = '{`ISR_ADDR_ALT, `ISR_ADDR_ID0,
        `ISR_ADDR_ID1, `ISR_ADDR_ID2, `ISR_ADDR_ID3, `ISR_ADDR_STAT,
        `ISR_ADDR_SHARED_DETECTOR_RESET, `ISR_ADDR_ASTR, `ISR_ADDR_BUS_TIMING_CONTROL};
    localparam logic [7:0] IDV[5] = '{8'h5A, 8'hF1, 8'h42, 8'h64, 8'h86};
    localparam logic [7:0] AB[4] = '{8'hF0, 8'h43, 8'h65, 8'h87};
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic idm = 1'b0;
    logic hgc = 1'b0;
    logic pready, perr, erv, txv, txr, mfl, sfl, fall, drst, sflag, sirq;
    logic am, gcm, held, av, gv;
    logic done_w = 1'b0;
    logic [1:0] aid;
    logic [7:0] ab, gb;
    logic [31:0] prdata, rdv;
    isr_apb_req_s apb_i = '0;
    isr_fifo_cnt_s cnt;
    isr_tx_s tx;
    isr_timing_s tim;
    int failures, n_compared, cyc;
    isr_regs isr_regs_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .apb_i(apb_i), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(perr), .per_id_fifo_mode_enable_i(idm),
        .hw_general_call_enable_i(hgc), .fifo_cnt_i(cnt),
        .slave_scl_held_i(held), .addr_valid_i(av), .addr_byte_i(ab),
        .gc_byte_valid_i(gv), .gc_byte_i(gb), .slave_tx_valid_o(txv),
        .slave_tx_ready_i(txr), .slave_tx_o(tx),
        .master_tx_fifo_flush_o(mfl), .slave_tx_fifo_flush_o(sfl),
        .flush_all_id_tx_fifos_o(fall), .detector_reset_o(drst),
        .timing_o(tim), .address_ack_irq_clear_o(),
        .slave_stretch_irq_flag_o(sflag), .slave_irq_o(sirq),
        .addr_match_o(am), .addr_match_id_o(aid), .gc_alt_match_o(gcm));
    isr_eng isr_eng_inst (.clk_i(clk_i), .tx_valid_i(txv), .tx_i(tx),
        .tx_ready_o(txr), .fifo_cnt_o(cnt), .held_o(held),
        .addr_valid_o(av), .addr_byte_o(ab), .gc_valid_o(gv), .gc_byte_o(gb));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // Ceiling well above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] g, e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [31:0] a,
                       input logic [15:0] d);
        int n;
        @(posedge clk_i);
        #1;
        apb_i = '{1'b1, 1'b0, w, a, {16'h0000, d}};
        @(posedge clk_i);
        #1;
        apb_i.enable = 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (pready !== 1'b1 && n < 200);
        rdv = prdata;
        erv = perr;
        @(posedge clk_i);
        #1;
        apb_i = '0;
    endtask : acc
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        acc(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [15:0] e);
        acc(1'b0, a, 16'h0000);
        chk($sformatf("reg %h", a), rdv, {16'h0000, e});
    endtask : rd
    task automatic drain;
        for (int n = 0; n < 100 && txv !== 1'b0; n++) begin
            @(posedge clk_i);
            #1;
        end
    endtask : drain
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (2) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        chk("timing", tim, 14'h0085);
        foreach (RA[i]) rd(RA[i], i == 8 ? 16'h0205 : 16'h0000);
        foreach (IDV[i]) begin
            wr(RA[i], {8'hFF, IDV[i]});
            rd(RA[i], {8'h00, IDV[i]});
        end
        foreach (AB[i]) begin
            isr_eng_inst.send(1'b0, AB[i]);
            chk("match", {am, aid}, {1'b1, i[1:0]});
        end
        isr_eng_inst.send(1'b0, 8'h10);
        chk("nomatch", am, 1'b0);
        isr_eng_inst.send(1'b1, 8'h5A);
        chk("gc off", gcm, 1'b0);
        hgc = 1'b1;
        isr_eng_inst.send(1'b1, 8'h5A);
        chk("gc", gcm, 1'b1);
        isr_eng_inst.send(1'b1, 8'h5B);
        chk("gc ne", gcm, 1'b0);
        $display("address test done");
        wr(`ISR_ADDR_BUS_TIMING_CONTROL, 16'hFFFF);
        rd(`ISR_ADDR_BUS_TIMING_CONTROL, 16'hFF3F);
        chk("timing", tim, 14'h3FFF);
        wr(`ISR_ADDR_SHARED_DETECTOR_RESET, 16'h0001);
        chk("detrst", drst, 1'b1);
        rd(`ISR_ADDR_SHARED_DETECTOR_RESET, 16'h0000);
        wr(`ISR_ADDR_SHARED_DETECTOR_RESET, 16'h0000);
        chk("detrst", drst, 1'b0);
        isr_eng_inst.fifo_cnt_o = 8'h92;
        wr(`ISR_ADDR_STAT, 16'h0200);
        chk("master_tx_fifo_flush", mfl, 1'b1);
        rd(`ISR_ADDR_STAT, 16'h0092);
        wr(`ISR_ADDR_STAT, 16'h0000);
        chk("master_tx_fifo_flush", mfl, 1'b0);
        acc(1'b0, 32'h4002_0900, 16'h0000);
        chk("unmapped", erv, 1'b1);
        wr(`ISR_ADDR_ASTR, 16'h4000);
        isr_eng_inst.held_o = 1'b1;
        rd(`ISR_ADDR_ASTR, 16'h4000);
        chk("stretch", {sflag, sirq}, 2'b11);
        wr(`ISR_ADDR_ASTR, 16'h8000);
        rd(`ISR_ADDR_ASTR, 16'h0000);
        chk("stretch", {sflag, sirq}, 2'b10);
        $display("control test done");
        idm = 1'b1;
        isr_eng_inst.stall = 1'b1;
        for (int i = 0; i < 4; i++)
            wr(`ISR_ADDR_STX, {6'h00, i[1:0], 8'hA0 + i[7:0]});
        idm = 1'b0;
        wr(`ISR_ADDR_STX, 16'h03CD);
        isr_eng_inst.stall = 1'b0;
        drain();
        for (int i = 0; i < 4; i++)
            chk("txid", isr_eng_inst.got[i],
                {i[1:0], 8'hA0 + i[7:0]});
        chk("txoff", isr_eng_inst.got[4], 10'h0CD);
        isr_eng_inst.got.delete();
        isr_eng_inst.stall = 1'b1;
        for (int i = 0; i < 32; i++)
            wr(`ISR_ADDR_STX, i[15:0]);
        fork
            begin
                wr(`ISR_ADDR_STX, 16'h00FF);
                done_w = 1'b1;
            end
            begin
                repeat (8) @(posedge clk_i);
                #1;
                chk("full", done_w, 1'b0);
                isr_eng_inst.stall = 1'b0;
            end
        join
        drain();
        chk("fill", isr_eng_inst.got.size(), 33);
        chk("last", isr_eng_inst.got[32], 10'h0FF);
        $display("fifo test done");
        isr_eng_inst.stall = 1'b1;
        wr(`ISR_ADDR_STX, 16'h0011);
        wr(`ISR_ADDR_STAT, 16'h0100);
        chk("slave_tx_fifo_flush", {sfl, txv}, 2'b10);
        wr(`ISR_ADDR_STAT, 16'h0000);
        chk("slave_tx_fifo_flush", txv, 1'b0);
        idm = 1'b1;
        wr(`ISR_ADDR_STX, 16'h0122);
        wr(`ISR_ADDR_STAT, 16'h0400);
        chk("fall", {fall, txv}, 2'b10);
        rd(`ISR_ADDR_STAT, 16'h0492);
        idm = 1'b0;
        @(posedge clk_i);
        #1;
        chk("fall", fall, 1'b0);
        $display("flush test done");
        end_sim();
    end
endmodule : i2c_slave_id_fifo_timing_regs_test

// ### verif/isr_eng.sv
`timescale 1ns/1ps
module isr_eng
    import isr_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Transmit stream
    input wire logic tx_valid_i,
    input isr_tx_s tx_i,
    output logic tx_ready_o,
    // Status and events
    output isr_fifo_cnt_s fifo_cnt_o,
    output logic held_o,
    output logic addr_valid_o,
    output logic [7:0] addr_byte_o,
    output logic gc_valid_o,
    output logic [7:0] gc_byte_o
);
    logic stall = 1'b0;
    isr_tx_s got[$];
    initial begin
        tx_ready_o = 1'b0;
        fifo_cnt_o = '0;
        held_o = 1'b0;
        addr_valid_o = 1'b0;
        addr_byte_o = 8'h00;
        gc_valid_o = 1'b0;
        gc_byte_o = 8'h00;
    end
    // Shifter takes a byte per cycle unless the bench stalls it
    always @(posedge clk_i) begin
        if (tx_valid_i && tx_ready_o)
            got.push_back(tx_i);
        tx_ready_o <= #1 !stall;
    end
    // Byte lines do not keep the old value once the strobe drops
    task automatic send(input logic gc, input logic [7:0] b);
        @(posedge clk_i);
        #1;
        gc_valid_o = gc;
        addr_valid_o = !gc;
        gc_byte_o = b;
        addr_byte_o = b;
        @(posedge clk_i);
        #1;
        gc_valid_o = 1'b0;
        addr_valid_o = 1'b0;
        gc_byte_o = ~b;
        addr_byte_o = ~b;
    endtask : send
endmodule : isr_eng

// ### verif/isr_regs_props.sv
`timescale 1ns/1ps
`include "isr_cfg.svh"
module isr_regs_props
    import isr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register bus
    input isr_apb_req_s apb_i,
    input wire logic pready_o,
    // Engine side
    input wire logic per_id_fifo_mode_enable_i,
    input wire logic hw_general_call_enable_i,
    input wire logic slave_scl_held_i,
    input wire logic gc_byte_valid_i,
    input wire logic slave_tx_valid_o,
    input wire logic slave_tx_fifo_flush_o,
    input wire logic flush_all_id_tx_fifos_o,
    input wire logic address_ack_irq_clear_o,
    input wire logic slave_stretch_irq_flag_o,
    input wire logic slave_irq_o,
    input wire logic gc_alt_match_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_take;
        apb_i.sel && apb_i.enable && !pready_o;
    endsequence
    sequence s_clr_wr;
        s_take ##0 (apb_i.write && apb_i.addr == `ISR_ADDR_ASTR
            && apb_i.wdata[15]);
    endsequence
    AST_RD_DONE: assert property (s_take ##0 !apb_i.write
        |=> pready_o) else $error("read not answered");
    AST_RDY_ONE: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    AST_ACK_CLR: assert property (s_clr_wr |=>
        address_ack_irq_clear_o ##1 !address_ack_irq_clear_o)
        else $error("ack clear pulse wrong");
    AST_IRQ: assert property (slave_irq_o |->
        slave_stretch_irq_flag_o) else $error("irq without stretch flag");
    AST_FLAG: assert property ($rose(slave_scl_held_i) |=>
        slave_stretch_irq_flag_o) else $error("stretch flag missed");
    AST_FLUSH_ALL: assert property (flush_all_id_tx_fifos_o |->
        $past(per_id_fifo_mode_enable_i) && !slave_tx_valid_o)
        else $error("flush all outside id mode or data offered");
    AST_FLUSH_EMPTY: assert property ((slave_tx_fifo_flush_o
        && !per_id_fifo_mode_enable_i) [*2] |-> !slave_tx_valid_o)
        else $error("data offered during flush");
    AST_GC: assert property (gc_alt_match_o |->
        $past(gc_byte_valid_i) && $past(hw_general_call_enable_i))
        else $error("stray gc match");
endmodule : isr_regs_props
bind isr_regs isr_regs_props isr_regs_props_inst (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .apb_i(apb_i), .pready_o(pready_o),
    .per_id_fifo_mode_enable_i(per_id_fifo_mode_enable_i),
    .hw_general_call_enable_i(hw_general_call_enable_i),
    .slave_scl_held_i(slave_scl_held_i), .gc_byte_valid_i(gc_byte_valid_i),
    .slave_tx_valid_o(slave_tx_valid_o),
    .slave_tx_fifo_flush_o(slave_tx_fifo_flush_o),
    .flush_all_id_tx_fifos_o(flush_all_id_tx_fifos_o),
    .address_ack_irq_clear_o(address_ack_irq_clear_o),
    .slave_stretch_irq_flag_o(slave_stretch_irq_flag_o),
    .slave_irq_o(slave_irq_o), .gc_alt_match_o(gc_alt_match_o));
